// file: core/stm_pkg.sv
// stm_pkg: constants for the standard timer block
// assumes a 32-bit axi4-lite register bus, byte registers in low bits
package stm_pkg;
    // -----------------------------------------
    // register byte addresses
    // -----------------------------------------
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
    localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
    localparam logic [7:0] ADDR_CMPA_HI = 8'h14;
    localparam logic [7:0] ADDR_PERIOD = 8'h18;
    localparam logic [7:0] ADDR_FLAGS = 8'h1C;
    // -----------------------------------------
    // control0 fields
    // -----------------------------------------
    localparam int CTRL0_PAUSE_POS = 7;
    localparam int CTRL0_CLKSEL_POS = 4;
    localparam int CTRL0_ENABLE_POS = 3;
    // -----------------------------------------
    // control1 fields
    // -----------------------------------------
    localparam int CTRL1_MODE_POS = 6;
    localparam int CTRL1_PIN_POS = 4;
    localparam int CTRL1_OC_POS = 3;
    localparam int CTRL1_INV_POS = 2;
    localparam int CTRL1_SWAP_POS = 1;
    localparam int CTRL1_CCLR_POS = 0;
    // flag register: bit0 match A, bit1 match P; write one to clear
    localparam int FLAG_A_POS = 0;
    localparam int FLAG_P_POS = 1;
    // -----------------------------------------
    // reset values
    // -----------------------------------------
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CMPA_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'h00;
    // -----------------------------------------
    // encodings
    // -----------------------------------------
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam logic [1:0] PIN_NONE = 2'h0;
    localparam logic [1:0] PIN_LOW = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;
    localparam logic [1:0] PIN_TOGGLE = 2'h3;
    localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CLK_SYS = 3'h1;
    localparam logic [2:0] CLK_H_DIV16 = 3'h2;
    localparam logic [2:0] CLK_H_DIV64 = 3'h3;
    localparam logic [2:0] CLK_EXT_RISE = 3'h6;
    localparam logic [2:0] CLK_EXT_FALL = 3'h7;
    // -----------------------------------------
    // divider counts and bus answers
    // -----------------------------------------
    localparam int DIV_SYS4 = 4;
    localparam int DIV_H16 = 16;
    localparam int DIV_H64 = 64;
    localparam int DIV_SUB = 256;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: core/stm_timer.sv
// stm_timer: 16-bit up-counting timer with compare A, period compare P and one output pin
// assumes one 100 MHz clock, async high reset, axi4-lite master, external clock pin asynchronous
//
// Contract
// - period byte matches counter high byte
// - compare A is sixteen bits, two bytes
// - mode codes select compare, timer, pwm; pwm with toggle pin code is pulse
// - clear-select low clears on P, both flags
// - clear-select high clears on A, A flag
// - zero A overflows at FFFF, no flag
// - compare pin moves only on A match or enable rise
// - enable rise loads pin with initial level
// - timer mode like compare, pin unused
// - pwm ignores clear-select, swap picks roles
// - swap zero period P, duty A
// - swap one period A, duty P times 256
// - pwm raises both match flags
// - pwm level, force codes and invert bit
// - pwm keeps running while pin forced
// - pulse mode external edge sets enable
// - pulse mode A match clears enable
// - pulse ignores P, counter zeroed on start
// - enable rise zeroes counter, fall holds it
// - compare pin codes none, low, high, toggle
`timescale 1ns/1ns
module stm_timer #(
    parameter int CNT_W = 16
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic externalClockPin, // external clock / trigger pin
    output logic timerOutputPin // timer output pin
);
    // -----------------------------------------
    // registers
    // -----------------------------------------
    logic [7:0] ctrl0_ff, ctrl1_ff, cmpALo_ff, cmpAHi_ff, period_ff;
    logic [CNT_W-1:0] count_ff;
    logic matchAFlag_ff, matchPFlag_ff, pinLevel_ff, enablePrev_ff;
    logic [2:0] extSync_ff;
    logic [7:0] div_ff;
    logic awHeld_ff, wHeld_ff;
    logic [7:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;

    // -----------------------------------------
    // field decode
    // -----------------------------------------
    wire timerEnable = ctrl0_ff[stm_pkg::CTRL0_ENABLE_POS];
    wire pauseBit = ctrl0_ff[stm_pkg::CTRL0_PAUSE_POS];
    wire [2:0] clkSel = ctrl0_ff[stm_pkg::CTRL0_CLKSEL_POS +: 3];
    wire [1:0] modeSel = ctrl1_ff[stm_pkg::CTRL1_MODE_POS +: 2];
    wire [1:0] pinAction = ctrl1_ff[stm_pkg::CTRL1_PIN_POS +: 2];
    wire outputControl = ctrl1_ff[stm_pkg::CTRL1_OC_POS];
    wire outputInvert = ctrl1_ff[stm_pkg::CTRL1_INV_POS];
    wire dutySwap = ctrl1_ff[stm_pkg::CTRL1_SWAP_POS];
    wire clearSelect = ctrl1_ff[stm_pkg::CTRL1_CCLR_POS];
    wire [15:0] compareA = {cmpAHi_ff, cmpALo_ff};

    // mode flags
    wire isPwmFamily = (modeSel == stm_pkg::MODE_PWM);
    wire isPulse = isPwmFamily && (pinAction == stm_pkg::PIN_TOGGLE);
    wire isPwm = isPwmFamily && !isPulse;
    wire isCompareLike = (modeSel == stm_pkg::MODE_COMPARE) || (modeSel == stm_pkg::MODE_TIMER);

    // -----------------------------------------
    // clock source selection
    // -----------------------------------------
    function automatic logic divTick(input logic [7:0] d, input int n);
        divTick = ((d % n) == 0);
    endfunction
    wire extRise = extSync_ff[1] && !extSync_ff[2];
    wire extFall = !extSync_ff[1] && extSync_ff[2];
    logic tick;
    always_comb
    begin
        case (clkSel)
            stm_pkg::CLK_SYS_DIV4: tick = divTick(div_ff, stm_pkg::DIV_SYS4);
            stm_pkg::CLK_SYS: tick = 1'b1;
            stm_pkg::CLK_H_DIV16: tick = divTick(div_ff, stm_pkg::DIV_H16);
            stm_pkg::CLK_H_DIV64: tick = divTick(div_ff, stm_pkg::DIV_H64);
            stm_pkg::CLK_EXT_RISE: tick = extRise;
            stm_pkg::CLK_EXT_FALL: tick = extFall;
            default: tick = divTick(div_ff, stm_pkg::DIV_SUB);
        endcase
    end
    // pulse trigger edge follows the clock select: falling for CLK_EXT_FALL, else rising
    wire extTrigger = (clkSel == stm_pkg::CLK_EXT_FALL) ? extFall : extRise;

    // -----------------------------------------
    // comparators
    // -----------------------------------------
    wire countStep = timerEnable && !pauseBit && tick;
    wire [CNT_W-1:0] countInc = count_ff + 1'b1;
    wire atMax = &count_ff;
    // P matches on the step from period byte times 256 minus one, or from FFFF when the byte is zero
    wire pMatch = countStep && ((period_ff == 8'h00) ? atMax : (countInc == {period_ff, 8'h00}));
    wire aMatch = countStep && (compareA != 16'h0000) && (countInc == compareA);
    wire overflow = countStep && atMax;

    // clear source per mode
    logic clearCount;
    always_comb
    begin
        if (isCompareLike)
            clearCount = clearSelect ? aMatch : pMatch;
        else if (isPwm)
            clearCount = dutySwap ? aMatch : pMatch;
        else
            clearCount = 1'b0;
    end
    wire raiseA = aMatch;
    // clear-select high suppresses P flag in compare and timer modes; pulse mode ignores P
    wire raiseP = pMatch && !isPulse && !(isCompareLike && clearSelect);

    // pwm active window
    wire [15:0] dutyValue = dutySwap ? {period_ff, 8'h00} : compareA;
    wire [16:0] periodValue = dutySwap ? {1'b0, compareA} : ((period_ff == 8'h00) ? 17'h10000 : {1'b0, period_ff, 8'h00});
    wire pwmActive = ({1'b0, dutyValue} >= periodValue) || (count_ff < dutyValue);

    // -----------------------------------------
    // bus write path
    // -----------------------------------------
    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire haveAw = awHeld_ff || awTake;
    wire haveW = wHeld_ff || wTake;
    wire doWrite = haveAw && haveW && !s_axi_bvalid;
    wire [7:0] wrAddr = awHeld_ff ? awAddr_ff : s_axi_awaddr;
    wire [31:0] wrData = wHeld_ff ? wData_ff : s_axi_wdata;
    wire [3:0] wrStrb = wHeld_ff ? wStrb_ff : s_axi_wstrb;
    wire wrByte0 = doWrite && wrStrb[0];
    wire wrKnown = (wrAddr == stm_pkg::ADDR_CTRL0) || (wrAddr == stm_pkg::ADDR_CTRL1)
        || (wrAddr == stm_pkg::ADDR_CMPA_LO) || (wrAddr == stm_pkg::ADDR_CMPA_HI)
        || (wrAddr == stm_pkg::ADDR_PERIOD) || (wrAddr == stm_pkg::ADDR_FLAGS)
        || (wrAddr == stm_pkg::ADDR_CNT_LO) || (wrAddr == stm_pkg::ADDR_CNT_HI);

    // next control0: software write, then hardware set/clear of enable
    logic [7:0] nxt_ctrl0;
    always_comb
    begin
        nxt_ctrl0 = ctrl0_ff;
        if (wrByte0 && wrAddr == stm_pkg::ADDR_CTRL0)
            nxt_ctrl0 = {wrData[7:3], 3'h0};
        if (isPulse && timerEnable && aMatch)
            nxt_ctrl0[stm_pkg::CTRL0_ENABLE_POS] = 1'b0;
        if (isPulse && !timerEnable && extTrigger)
            nxt_ctrl0[stm_pkg::CTRL0_ENABLE_POS] = 1'b1;
    end
    wire enableRise = timerEnable && !enablePrev_ff;

    // control and compare registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl0_ff <= stm_pkg::CTRL0_RESET;
            ctrl1_ff <= stm_pkg::CTRL1_RESET;
            cmpALo_ff <= stm_pkg::CMPA_RESET;
            cmpAHi_ff <= stm_pkg::CMPA_RESET;
            period_ff <= stm_pkg::PERIOD_RESET;
        end
        else
        begin
            ctrl0_ff <= nxt_ctrl0;
            if (wrByte0 && wrAddr == stm_pkg::ADDR_CTRL1)
                ctrl1_ff <= wrData[7:0];
            if (wrByte0 && wrAddr == stm_pkg::ADDR_CMPA_LO)
                cmpALo_ff <= wrData[7:0];
            if (wrByte0 && wrAddr == stm_pkg::ADDR_CMPA_HI)
                cmpAHi_ff <= wrData[7:0];
            if (wrByte0 && wrAddr == stm_pkg::ADDR_PERIOD)
                period_ff <= wrData[7:0];
        end
    end

    // -----------------------------------------
    // counter, flags, pin
    // -----------------------------------------
    wire flagClrA = wrByte0 && wrAddr == stm_pkg::ADDR_FLAGS && wrData[stm_pkg::FLAG_A_POS];
    wire flagClrP = wrByte0 && wrAddr == stm_pkg::ADDR_FLAGS && wrData[stm_pkg::FLAG_P_POS];
    logic nxt_pin;
    always_comb
    begin
        nxt_pin = pinLevel_ff;
        if (enableRise)
            nxt_pin = outputControl;
        else if (isCompareLike && aMatch)
        begin
            case (pinAction)
                stm_pkg::PIN_LOW: nxt_pin = 1'b0;
                stm_pkg::PIN_HIGH: nxt_pin = 1'b1;
                stm_pkg::PIN_TOGGLE: nxt_pin = !pinLevel_ff;
                default: nxt_pin = pinLevel_ff;
            endcase
        end
    end
    // pwm pin: forced codes or waveform at chosen level, then invert
    logic pwmPin;
    always_comb
    begin
        case (pinAction)
            stm_pkg::PIN_NONE: pwmPin = !outputControl;
            stm_pkg::PIN_LOW: pwmPin = outputControl;
            default: pwmPin = pwmActive ? outputControl : !outputControl;
        endcase
    end
    // pulse: active level while enabled, else inactive
    wire pulsePin = timerEnable ? outputControl : !outputControl;
    logic nxt_out;
    always_comb
    begin
        if (modeSel == stm_pkg::MODE_TIMER)
            nxt_out = 1'b0;
        else if (isPulse)
            nxt_out = pulsePin ^ outputInvert;
        else if (isPwm)
            nxt_out = pwmPin ^ outputInvert;
        else
            nxt_out = nxt_pin ^ outputInvert;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count_ff <= '0;
            matchAFlag_ff <= 1'b0;
            matchPFlag_ff <= 1'b0;
            pinLevel_ff <= 1'b0;
            enablePrev_ff <= 1'b0;
            timerOutputPin <= 1'b0;
        end
        else
        begin
            enablePrev_ff <= timerEnable;
            pinLevel_ff <= nxt_pin;
            timerOutputPin <= nxt_out;
            if (enableRise)
                count_ff <= '0;
            else if (clearCount || overflow)
                count_ff <= '0;
            else if (countStep)
                count_ff <= countInc;
            matchAFlag_ff <= raiseA || (matchAFlag_ff && !flagClrA);
            matchPFlag_ff <= raiseP || (matchPFlag_ff && !flagClrP);
        end
    end

    // prescaler and external pin synchroniser
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_ff <= 8'h00;
            extSync_ff <= 3'h0;
        end
        else
        begin
            div_ff <= div_ff + 8'h01;
            extSync_ff <= {extSync_ff[1:0], externalClockPin};
        end
    end

    // -----------------------------------------
    // bus handshake
    // -----------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff <= 32'h0000_0000;
            wStrb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= stm_pkg::RESP_OKAY;
        end
        else
        begin
            if (awTake)
                awAddr_ff <= s_axi_awaddr;
            if (wTake)
            begin
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            awHeld_ff <= haveAw && !doWrite;
            wHeld_ff <= haveW && !doWrite;
            s_axi_awready <= !(haveAw) && !s_axi_bvalid && !doWrite;
            s_axi_wready <= !(haveW) && !s_axi_bvalid && !doWrite;
            if (doWrite)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrKnown ? stm_pkg::RESP_OKAY : stm_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read decode
    logic [7:0] rdByte;
    logic rdKnown;
    always_comb
    begin
        rdKnown = 1'b1;
        case (s_axi_araddr)
            stm_pkg::ADDR_CTRL0: rdByte = ctrl0_ff;
            stm_pkg::ADDR_CTRL1: rdByte = ctrl1_ff;
            stm_pkg::ADDR_CNT_LO: rdByte = count_ff[7:0];
            stm_pkg::ADDR_CNT_HI: rdByte = count_ff[15:8];
            stm_pkg::ADDR_CMPA_LO: rdByte = cmpALo_ff;
            stm_pkg::ADDR_CMPA_HI: rdByte = cmpAHi_ff;
            stm_pkg::ADDR_PERIOD: rdByte = period_ff;
            stm_pkg::ADDR_FLAGS: rdByte = {6'h00, matchPFlag_ff, matchAFlag_ff};
            default:
            begin
                rdByte = 8'h00;
                rdKnown = 1'b0;
            end
        endcase
    end
    wire arTake = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= stm_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !arTake;
            if (arTake)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rdByte};
                s_axi_rresp <= rdKnown ? stm_pkg::RESP_OKAY : stm_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // -----------------------------------------
    // checks
    // -----------------------------------------
    sequence s_enable_rise;
        timerEnable && !enablePrev_ff;
    endsequence
    a_count_zero_start: assert property (@(posedge clk) disable iff (sys_rst)
        s_enable_rise |=> (count_ff == '0))
        else $error("counter not zeroed on enable rise");
    a_pin_init_level: assert property (@(posedge clk) disable iff (sys_rst)
        (s_enable_rise and isCompareLike && modeSel == stm_pkg::MODE_COMPARE) |=> (timerOutputPin == (outputControl ^ outputInvert)))
        else $error("pin not set to initial level");
    a_no_p_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (isCompareLike && clearSelect && !matchPFlag_ff) |=> !matchPFlag_ff)
        else $error("P flag raised with clear-select high");
    a_pulse_stop: assert property (@(posedge clk) disable iff (sys_rst)
        (isPulse && timerEnable && aMatch) |=> !timerEnable)
        else $error("pulse not ended by A match");
    a_pulse_start: assert property (@(posedge clk) disable iff (sys_rst)
        (isPulse && !timerEnable && extTrigger) |=> timerEnable)
        else $error("pulse not started by pin edge");
    a_a_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
        aMatch |=> matchAFlag_ff)
        else $error("A flag missing after match");
    a_zero_a_overflow: assert property (@(posedge clk) disable iff (sys_rst)
        (compareA == 16'h0000 && isCompareLike && clearSelect && countStep && atMax) |=> (count_ff == '0) && !$past(aMatch))
        else $error("zero A did not overflow cleanly");
    a_hold_on_stop: assert property (@(posedge clk) disable iff (sys_rst)
        (!timerEnable && !enableRise ##1 !timerEnable) |-> $stable(count_ff))
        else $error("counter moved while stopped");
    a_p_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (isCompareLike && !clearSelect && pMatch && !enableRise) |=> (count_ff == '0) && matchPFlag_ff)
        else $error("P match did not clear counter");
endmodule

// file: sim/stm_far_side.sv
// stm_far_side: trigger source on the external clock pin and load on the output pin
// assumes the bench raises fire once per trigger and holds measure over a window
`timescale 1ns/1ns
module stm_far_side (
    input wire logic clk, // system clock
    input wire logic fire, // rising edge asks for one trigger
    input wire logic measure, // count window
    input wire logic loadPin, // timer output pin
    output logic extPin, // external clock pin, idles low
    output int highCnt, // samples seen high
    output int edgeCnt // level changes seen
);
    logic lastPin;
    // trigger edge out of phase with clk, pin stands low between triggers
    initial extPin = 1'b0;
    always @(posedge fire)
    begin
        #3 extPin = 1'b1;
        repeat (8) @(posedge clk);
        #4 extPin = 1'b0;
    end
    // load observer, cleared outside the window
    always @(posedge clk)
    begin
        highCnt <= measure ? highCnt + int'(loadPin) : 0;
        edgeCnt <= measure ? edgeCnt + int'(loadPin != lastPin) : 0;
        lastPin <= loadPin;
    end
endmodule

// file: sim/tb_standard_timer_compare_pwm.sv
// tb_standard_timer_compare_pwm: self-checking bench with an integer pwm model
// assumes stm_pkg, stm_timer and stm_far_side compiled first
`timescale 1ns/1ns
`define CHK(g, e) \
    begin \
        nCompared++; \
        if ((g) !== (e)) \
        begin \
            failCount++; \
            $display("unexpected at %0t got %h expected %h", $time, (g), (e)); \
        end \
    end
module tb_standard_timer_compare_pwm;
    logic clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fire, measure;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, externalClockPin, timerOutputPin;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rd, regModel [8];
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int failCount, nCompared, highCnt, edgeCnt, e;
    // pwm cases: control1, compare a, expected flags
    logic [7:0] pc1 [7] = '{8'hA8, 8'hA9, 8'hA8, 8'hAA, 8'hAC, 8'h98, 8'h88};
    logic [15:0] pa [7] = '{16'h0080, 16'h0080, 16'h0200, 16'h0300, 16'h0040, 16'h0040, 16'h0040};
    logic [1:0] pfl [7] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
    stm_timer uut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .externalClockPin, .timerOutputPin);
    stm_far_side far (.clk, .fire, .measure, .loadPin(timerOutputPin), .extPin(externalClockPin), .highCnt, .edgeCnt);
    // clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic giveVerdict();
        $display("compares %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic hang();
        failCount++;
        giveVerdict();
    endtask
    // bus write, address and data offered together, released as each is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            n++;
        end
        while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        regModel[a[4:2]] = d;
        if (n >= 100) hang();
    endtask
    // bus read of one byte register
    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            n++;
        end
        while (s_axi_rvalid !== 1'b1 && n < 100);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        if (n >= 100) hang();
    endtask
    // stop, configure, clear flags, then write the run byte
    task automatic run(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] en);
        wr(stm_pkg::ADDR_CTRL0, 8'h10);
        wr(stm_pkg::ADDR_CTRL1, c1);
        wr(stm_pkg::ADDR_CMPA_LO, a[7:0]);
        wr(stm_pkg::ADDR_CMPA_HI, a[15:8]);
        wr(stm_pkg::ADDR_PERIOD, 8'h01);
        wr(stm_pkg::ADDR_FLAGS, 8'h03);
        wr(stm_pkg::ADDR_CTRL0, en);
    endtask
    task automatic meas(input int n);
        @(posedge clk);
        measure <= 1'b1;
        repeat (n) @(posedge clk);
        measure <= 1'b0;
        #1;
    endtask
    // model: high samples of the pin over cyc cycles, period byte fixed at 1
    function automatic int pwmHigh(input logic [7:0] c1, input int a, input int cyc);
        int per, duty, act;
        per = c1[1] ? a : 256;
        duty = c1[1] ? 256 : a;
        act = (cyc / per) * (duty < per ? duty : per);
        if (c1[5:4] == 2'h0) act = 0;
        if (c1[5:4] == 2'h1) act = cyc;
        return (c1[3] ^ c1[2]) ? act : cyc - act;
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fire, measure} = '0;
        s_axi_wstrb = 4'hF;
        failCount = 0;
        nCompared = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        void'($urandom(32'h433d));
        // compare bytes: reset value, random write, read back
        for (int i = 4; i < 7; i++)
        begin
            rdr(8'(i * 4));
            `CHK(rd, 8'h00)
            wr(8'(i * 4), 8'($urandom));
            `CHK(resp, stm_pkg::RESP_OKAY)
            rdr(8'(i * 4));
            `CHK(rd, regModel[i])
        end
        rdr(8'h20);
        `CHK(resp, stm_pkg::RESP_SLVERR)
        // compare mode, clear on A, every pin code
        for (int k = 0; k < 4; k++)
        begin
            run({2'b00, 2'(k), ~k[1], 3'b001}, 16'h0020, 8'h18);
            repeat (15) @(posedge clk);
            `CHK(timerOutputPin, ~k[1])
            repeat (25) @(posedge clk);
            `CHK(timerOutputPin, logic'(k != 1))
            meas(320);
            `CHK(edgeCnt, (k == 3) ? 10 : 0)
            rdr(stm_pkg::ADDR_FLAGS);
            `CHK(rd, 8'h01)
            rdr(stm_pkg::ADDR_CNT_LO);
            `CHK(rd < 8'h20, 1'b1)
        end
        // clear on P, one A match per 256 clocks
        run(8'h30, 16'h0010, 8'h18);
        meas(512);
        `CHK(edgeCnt, 2)
        rdr(stm_pkg::ADDR_FLAGS);
        `CHK(rd, 8'h03)
        rdr(stm_pkg::ADDR_CNT_HI);
        `CHK(rd, 8'h00)
        // timer mode holds the pin low
        run(8'hF8, 16'h0010, 8'h18);
        meas(300);
        `CHK(highCnt, 0)
        rdr(stm_pkg::ADDR_FLAGS);
        `CHK(rd, 8'h03)
        // clk/4 prescaler: toggle every 32 ticks, 128 clocks
        run(8'h31, 16'h0020, 8'h08);
        meas(512);
        `CHK(edgeCnt, 4)
        // timer mode, zero A, clear on A: free run past FFFF, P below A, no flags
        run(8'hC1, 16'h0000, 8'h18);
        repeat (65545) @(posedge clk);
        rdr(stm_pkg::ADDR_FLAGS);
        `CHK(rd, 8'h00)
        // pwm cases against the model
        for (int i = 0; i < 7; i++)
        begin
            run(pc1[i], pa[i], 8'h18);
            meas(1536);
            e = pwmHigh(pc1[i], int'(pa[i]), 1536);
            `CHK(highCnt inside {[e - 6:e + 6]}, 1'b1)
            rdr(stm_pkg::ADDR_FLAGS);
            `CHK(rd[1:0], pfl[i])
        end
        // single pulse started by the external pin, ended by A
        run(8'hB8, 16'h0020, 8'h10);
        fire <= 1'b1;
        meas(100);
        fire <= 1'b0;
        `CHK(highCnt inside {[30:34]}, 1'b1)
        rdr(stm_pkg::ADDR_CTRL0);
        `CHK(rd, 8'h10)
        giveVerdict();
    end
endmodule
